// >>> include/dma_pkg.sv
// Constants, types and state codes of the ten-channel transfer engine.
// Assumes one 25 MHz clock and a 64 Kbyte peripheral/RAM bus window.
package dma_pkg;
  localparam int NCH = 10;
  localparam int CH_W = 4;
  localparam int CNT_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int NSRC = 4;
  localparam int SEL_W = 2;
  localparam int BUF_DEPTH = 2;
  localparam int BUF_CNT_W = 2;
  // Window base; the engine only drives the low 16 address bits
  localparam logic [31:0] WINDOW_BASE = 32'h0080_0000;
  localparam logic [CNT_W-1:0] CNT_UNDERFLOW = 8'hFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam int RING8_BITS = 5;
  localparam int RING16_BITS = 6;
  localparam logic [ADDR_W-1:0] STEP8 = 16'h0001;
  localparam logic [ADDR_W-1:0] STEP16 = 16'h0002;
  localparam int XFER_CYCLES = 3;
  localparam logic [CH_W-1:0] CH_NONE = 4'hF;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ACQ = 4'h2,
    ST_RD = 4'h4,
    ST_WR = 4'h8
  } dma_state_t;
endpackage : dma_pkg

// >>> core/dma_hold_buffer.sv
// Two-entry hold buffer between the source read and destination write.
// Assumes the producer honours in_ready and the consumer out_ready.
`timescale 1ns/100ps
module dma_hold_buffer
  import dma_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [DATA_W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [DATA_W-1:0] out_data
);
  typedef struct packed {
    logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
    logic [BUF_CNT_W-1:0] cnt;
  } hold_t;

  hold_t q_r;
  hold_t q_nxt;
  logic push;
  logic pop;

  // Head always sits in entry 0, so the data output is a plain flop
  assign in_ready = (q_r.cnt < BUF_CNT_W'(BUF_DEPTH));
  assign out_valid = (q_r.cnt != '0);
  assign out_data = q_r.mem[0];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Shift on pop, then drop a new word behind the last held one
  always_comb begin
    q_nxt = q_r;
    if (pop) begin
      for (int i = 0; i < BUF_DEPTH - 1; i++) begin
        q_nxt.mem[i] = q_r.mem[i+1];
      end
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
    if (push) begin
      q_nxt.mem[q_nxt.cnt[0]] = in_data;
      q_nxt.cnt = q_nxt.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end
endmodule : dma_hold_buffer

// >>> core/dma_channel_transfer_engine.sv
// Ten-channel dual-address transfer engine with software control as ports.
// Assumes synchronous inputs; read data is valid during the read cycle.
`timescale 1ns/100ps
module dma_channel_transfer_engine
  import dma_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [NCH-1:0] enable_set,
  input wire logic [NCH-1:0] enable_clr,
  input wire logic [NCH-1:0] ring_mode,
  input wire logic [NCH-1:0] source_direction_select,
  input wire logic [NCH-1:0] destination_direction_select,
  input wire logic [NCH-1:0] unit_size_select,
  input wire logic [NCH-1:0][SEL_W-1:0] request_source_select,
  input wire logic [NCH-1:0][NSRC-1:0] request_in,
  input wire logic [NCH-1:0] req_flag_clr,
  input wire logic [NCH-1:0] cnt_wr,
  input wire logic [NCH-1:0] src_wr,
  input wire logic [NCH-1:0] dst_wr,
  input wire logic [ADDR_W-1:0] sw_wdata,
  input wire logic status_wr,
  input wire logic [NCH-1:0] status_wdata,
  input wire logic [NCH-1:0] irq_mask,
  input wire logic bus_gnt,
  input wire logic [DATA_W-1:0] bus_rdata,
  input wire logic bus_wr_ready,
  output logic [NCH-1:0] channel_transfer_enable,
  output logic [NCH-1:0] req_flag,
  output logic [NCH-1:0] irq_status,
  output logic dma_irq,
  output logic [NCH-1:0][CNT_W-1:0] xfer_count,
  output logic [NCH-1:0][ADDR_W-1:0] src_addr,
  output logic [NCH-1:0][ADDR_W-1:0] dst_addr,
  output logic [CH_W-1:0] active_chan,
  output logic bus_req,
  output logic bus_rd,
  output logic bus_wr,
  output logic bus_size16,
  output logic [ADDR_W-1:0] bus_addr,
  output logic [DATA_W-1:0] bus_wdata
);
  typedef struct packed {
    dma_state_t st;
    logic [CH_W-1:0] cur;
    logic [NCH-1:0] en;
    logic [NCH-1:0] flag;
    logic [NCH-1:0] stat;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0][ADDR_W-1:0] src;
    logic [NCH-1:0][ADDR_W-1:0] dst;
    logic [ADDR_W-1:0] addr;
    logic size16;
    logic irq;
  } eng_t;

  eng_t s_r;
  eng_t s_nxt;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [DATA_W-1:0] rd_byte;
  logic [DATA_W-1:0] buf_in_data;
  logic wr_done;
  logic [NCH-1:0] pending;
  logic [CH_W-1:0] pick;

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  // Next address: fixed, linear, or wrapping inside the ring block
  function automatic logic [ADDR_W-1:0] advance(
    input logic [ADDR_W-1:0] a,
    input logic inc,
    input logic h16,
    input logic ring
  );
    logic [ADDR_W-1:0] step;
    logic [ADDR_W-1:0] lin;
    step = h16 ? STEP16 : STEP8;
    lin = a + step;
    advance = a;
    if (inc && !ring) begin
      advance = lin;
    end else if (inc && !h16) begin
      advance = {a[ADDR_W-1:RING8_BITS], lin[RING8_BITS-1:0]};
    end else if (inc) begin
      advance = {a[ADDR_W-1:RING16_BITS], lin[RING16_BITS-1:0]};
    end
  endfunction : advance

  // Halfword units drop bit 0 so the bus sees an aligned access
  function automatic logic [ADDR_W-1:0] bus_align(
    input logic [ADDR_W-1:0] a,
    input logic h16
  );
    bus_align = h16 ? {a[ADDR_W-1:1], 1'b0} : a;
  endfunction : bus_align

  // -----------------------------------------------------------------
  // Arbitration and data path
  // -----------------------------------------------------------------
  // Fixed priority, channel 0 first; loop runs downward so low wins
  always_comb begin
    pending = s_r.en & s_r.flag;
    pick = CH_NONE;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pending[i]) begin
        pick = CH_W'(i);
      end
    end
  end

  // Byte units take the lane named by bit 0 and repeat it on both lanes,
  // so any source byte can land on any destination byte
  always_comb begin
    rd_byte = s_r.src[s_r.cur][0] ? {bus_rdata[7:0], bus_rdata[7:0]}
                                  : {bus_rdata[15:8], bus_rdata[15:8]};
    buf_in_data = s_r.size16 ? bus_rdata : rd_byte;
  end

  assign wr_done = (s_r.st == ST_WR) && bus_wr_ready && buf_out_valid;

  // Read data is held here between the two bus cycles
  dma_hold_buffer u_hold (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(s_r.st == ST_RD),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready((s_r.st == ST_WR) && bus_wr_ready),
    .out_data(bus_wdata)
  );

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    logic [CH_W-1:0] c;
    logic go;
    s_nxt = s_r;
    c = s_r.cur;
    go = 1'b0;

    // Software writes; enable clear beats set in the same cycle
    for (int i = 0; i < NCH; i++) begin
      if (enable_set[i]) begin
        s_nxt.en[i] = 1'b1;
      end
      if (enable_clr[i]) begin
        s_nxt.en[i] = 1'b0;
      end
      if (cnt_wr[i] && !s_r.en[i]) begin
        s_nxt.cnt[i] = sw_wdata[CNT_W-1:0];
      end
      if (src_wr[i]) begin
        s_nxt.src[i] = sw_wdata;
      end
      if (dst_wr[i]) begin
        s_nxt.dst[i] = sw_wdata;
      end
      if (req_flag_clr[i]) begin
        s_nxt.flag[i] = 1'b0;
      end
      if (status_wr && !status_wdata[i]) begin
        s_nxt.stat[i] = 1'b0;
      end
    end

    unique case (s_r.st)
      ST_IDLE: go = (pick != CH_NONE);
      ST_ACQ: begin
        if (bus_gnt) begin
          s_nxt.st = ST_RD;
          s_nxt.addr = bus_align(s_r.src[c], s_r.size16);
        end
      end
      ST_RD: begin
        if (buf_in_ready) begin
          s_nxt.st = ST_WR;
          s_nxt.addr = bus_align(s_r.dst[c], s_r.size16);
        end
      end
      ST_WR: begin
        if (wr_done) begin
          s_nxt.src[c] = advance(s_r.src[c], source_direction_select[c],
                                 s_r.size16, ring_mode[c]);
          s_nxt.dst[c] = advance(s_r.dst[c],
                                 destination_direction_select[c],
                                 s_r.size16, ring_mode[c]);
          s_nxt.cnt[c] = s_r.cnt[c] - 1'b1;
          if (!ring_mode[c] && s_r.cnt[c] == CNT_ZERO) begin
            s_nxt.en[c] = 1'b0;
            s_nxt.stat[c] = 1'b1;
          end
          s_nxt.st = ST_IDLE;
          go = (pick != CH_NONE);
        end
      end
    endcase

    // Next channel is claimed at once, so back-to-back costs no idle;
    // a channel that is just ending or being switched off is passed by
    if (go && s_nxt.en[pick]) begin
      s_nxt.st = ST_ACQ;
      s_nxt.cur = pick;
      s_nxt.size16 = unit_size_select[pick];
      s_nxt.flag[pick] = 1'b0;
    end

    // Requests set last so a same-cycle clear never loses one
    for (int i = 0; i < NCH; i++) begin
      if (s_r.en[i] && request_in[i][request_source_select[i]]) begin
        s_nxt.flag[i] = 1'b1;
      end
    end
    s_nxt.irq = |(s_nxt.stat & ~irq_mask);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: ST_IDLE, cur: CH_NONE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Outputs, all taken from flops
  // -----------------------------------------------------------------
  assign channel_transfer_enable = s_r.en;
  assign req_flag = s_r.flag;
  assign irq_status = s_r.stat;
  assign dma_irq = s_r.irq;
  assign xfer_count = s_r.cnt;
  assign src_addr = s_r.src;
  assign dst_addr = s_r.dst;
  assign active_chan = s_r.cur;
  assign bus_req = (s_r.st == ST_ACQ);
  assign bus_rd = (s_r.st == ST_RD);
  assign bus_wr = (s_r.st == ST_WR);
  assign bus_size16 = s_r.size16;
  assign bus_addr = s_r.addr;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  // Snapshot of the channel just finished, for post-completion checks
  logic done_q;
  logic [CH_W-1:0] ch_q;
  logic [ADDR_W-1:0] src_q;
  logic [CNT_W-1:0] cnt_q;
  logic ring_q;
  logic inc_q;
  logic h16_q;
  logic stat_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      ch_q <= '0;
      src_q <= '0;
      cnt_q <= '0;
      ring_q <= 1'b0;
      inc_q <= 1'b0;
      h16_q <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      done_q <= wr_done;
      ch_q <= s_r.cur;
      src_q <= s_r.src[s_r.cur];
      cnt_q <= s_r.cnt[s_r.cur];
      ring_q <= ring_mode[s_r.cur];
      inc_q <= source_direction_select[s_r.cur];
      h16_q <= s_r.size16;
      stat_q <= s_r.stat[s_r.cur];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_three_cycle: assert property (
      bus_req && bus_gnt |=> bus_rd ##1 bus_wr)
    else $error("transfer did not run acquire, read, write");
  a_rd_src_addr: assert property (
      $rose(bus_rd) |->
      bus_addr == bus_align(src_addr[active_chan], bus_size16))
    else $error("read address is not the source address");
  a_count_guard: assert property (
      |(channel_transfer_enable & cnt_wr) && !wr_done
      && (cnt_wr & ~channel_transfer_enable) == '0
      |=> $stable(xfer_count))
    else $error("count changed by a write while enabled");
  a_fixed_addr: assert property (
      done_q && !inc_q |-> src_addr[ch_q] == src_q)
    else $error("fixed source address moved");
  a_lin_step: assert property (
      done_q && inc_q && !ring_q |->
      src_addr[ch_q] == src_q + (h16_q ? STEP16 : STEP8))
    else $error("linear source step wrong");
  a_ring_wrap8: assert property (
      done_q && inc_q && ring_q && !h16_q && src_q[4:0] == 5'h1F
      |-> src_addr[ch_q] == {src_q[15:5], 5'h00})
    else $error("byte ring did not wrap");
  a_ring_wrap16: assert property (
      done_q && inc_q && ring_q && h16_q && src_q[5:0] == 6'h3E
      |-> src_addr[ch_q] == {src_q[15:6], 6'h00})
    else $error("halfword ring did not wrap");
  a_underflow_end: assert property (
      done_q && !ring_q && cnt_q == CNT_ZERO
      |-> !channel_transfer_enable[ch_q] && irq_status[ch_q]
      && xfer_count[ch_q] == CNT_UNDERFLOW)
    else $error("underflow did not end the run");
  a_ring_no_irq: assert property (
      done_q && ring_q && !stat_q |-> !irq_status[ch_q])
    else $error("ring mode raised completion");
  a_priority: assert property (
      (s_r.st == ST_IDLE) && pending[0] && !enable_clr[0]
      |=> active_chan == 0 && bus_req)
    else $error("channel 0 not granted first");
  a_status_keep: assert property (
      status_wr |=> ($past(irq_status) & $past(status_wdata)
      & ~irq_status) == '0)
    else $error("status bit cleared by a one write");

  c_normal_end: cover property (done_q && !ring_q && cnt_q == CNT_ZERO);
  c_ring_wrap: cover property (done_q && ring_q && src_q[4:0] == 5'h1F);
  c_back_to_back: cover property (bus_wr ##1 bus_req);
  c_write_stall: cover property (bus_wr && !bus_wr_ready);
endmodule : dma_channel_transfer_engine

// >>> verif/dma_bus_partner.sv
// Bus partner: peripheral/RAM window seen by the transfer engine.
// Assumes the engine holds each request until this model answers it.
`timescale 1ns/100ps
module dma_bus_partner
  import dma_pkg::*;
(
  input wire logic mclk,
  input wire logic bus_req,
  input wire logic bus_rd,
  input wire logic bus_wr,
  input wire logic bus_size16,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wdata,
  input wire logic slow,
  input wire logic hold,
  output logic bus_gnt,
  output logic [DATA_W-1:0] bus_rdata,
  output logic bus_wr_ready,
  output int wr_count,
  output int busy_cycles
);
  logic [DATA_W-1:0] mem [0:32767];
  logic tog_r = 1'b0;

  // Known pattern so every moved unit can be traced
  initial begin
    wr_count = 0;
    busy_cycles = 0;
    for (int i = 0; i < 32768; i++) begin
      mem[i] = 16'(i * 16'h0123 + 16'h5A00);
    end
  end

  // Slow mode answers every other cycle; hold keeps the CPU on the bus
  assign bus_gnt = bus_req && !hold && (!slow || tog_r);
  assign bus_wr_ready = bus_wr && (!slow || tog_r);
  // Released data lines toggle so stale data can never match
  assign bus_rdata = bus_rd ? mem[bus_addr[15:1]] : {16{tog_r}} ^ 16'hA5A5;

  // Byte lane from address bit 0, halfword whole
  always @(posedge mclk) begin
    tog_r <= !tog_r;
    if (bus_req || bus_rd || bus_wr) begin
      busy_cycles <= busy_cycles + 1;
    end
    if (bus_wr && bus_wr_ready) begin
      wr_count <= wr_count + 1;
      if (bus_size16) begin
        mem[bus_addr[15:1]] <= bus_wdata;
      end else if (bus_addr[0]) begin
        mem[bus_addr[15:1]][7:0] <= bus_wdata[7:0];
      end else begin
        mem[bus_addr[15:1]][15:8] <= bus_wdata[15:8];
      end
    end
  end
endmodule : dma_bus_partner

// >>> verif/dma_channel_transfer_engine_tb.sv
// Self-checking bench for the ten-channel transfer engine.
// Assumes dma_bus_partner answers the engine's internal bus cycles.
`timescale 1ns/100ps
module dma_channel_transfer_engine_tb
  import dma_pkg::*;
;
  localparam int K_CNT = 0;
  localparam int K_SRC = 1;
  localparam int K_DST = 2;
  localparam int K_EN = 3;
  localparam int K_OFF = 4;
  localparam int K_FCLR = 5;
  localparam int K_STAT = 6;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [NCH-1:0] enable_set, enable_clr, ring_mode, req_flag_clr;
  logic [NCH-1:0] source_direction_select, destination_direction_select;
  logic [NCH-1:0] unit_size_select, cnt_wr, src_wr, dst_wr;
  logic [NCH-1:0] status_wdata, irq_mask;
  logic [NCH-1:0][SEL_W-1:0] request_source_select;
  logic [NCH-1:0][NSRC-1:0] request_in;
  logic [ADDR_W-1:0] sw_wdata, bus_addr;
  logic status_wr, slow, hold, dma_irq, bus_req, bus_rd, bus_wr;
  logic bus_size16, bus_gnt, bus_wr_ready;
  logic [NCH-1:0] channel_transfer_enable, req_flag, irq_status;
  logic [NCH-1:0][CNT_W-1:0] xfer_count;
  logic [NCH-1:0][ADDR_W-1:0] src_addr, dst_addr;
  logic [CH_W-1:0] active_chan;
  logic [DATA_W-1:0] bus_wdata, bus_rdata;
  int wr_count, busy_cycles, w0, b0, n;
  int err_count = 0;
  int samples_checked = 0;

  // 25 MHz clock
  always #20 mclk = ~mclk;

  dma_channel_transfer_engine i_dma_channel_transfer_engine (
    .mclk, .resetn, .enable_set, .enable_clr, .ring_mode,
    .source_direction_select, .destination_direction_select,
    .unit_size_select, .request_source_select, .request_in,
    .req_flag_clr, .cnt_wr, .src_wr, .dst_wr, .sw_wdata, .status_wr,
    .status_wdata, .irq_mask, .bus_gnt, .bus_rdata, .bus_wr_ready,
    .channel_transfer_enable, .req_flag, .irq_status, .dma_irq,
    .xfer_count, .src_addr, .dst_addr, .active_chan, .bus_req, .bus_rd,
    .bus_wr, .bus_size16, .bus_addr, .bus_wdata
  );

  dma_bus_partner i_dma_bus_partner (
    .mclk, .bus_req, .bus_rd, .bus_wr, .bus_size16, .bus_addr,
    .bus_wdata, .slow, .hold, .bus_gnt, .bus_rdata, .bus_wr_ready,
    .wr_count, .busy_cycles
  );

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // One-cycle software strobe, launched at the falling edge
  task automatic write_reg(input int k, input logic [NCH-1:0] m,
                           input logic [15:0] d);
    @(negedge mclk);
    sw_wdata = d;
    case (k)
      K_CNT: cnt_wr = m;
      K_SRC: src_wr = m;
      K_DST: dst_wr = m;
      K_EN: enable_set = m;
      K_OFF: enable_clr = m;
      K_FCLR: req_flag_clr = m;
      default: begin
        status_wr = 1'b1;
        status_wdata = m;
      end
    endcase
    @(negedge mclk);
    {cnt_wr, src_wr, dst_wr, enable_set, enable_clr, req_flag_clr} = '0;
    status_wr = 1'b0;
  endtask : write_reg

  // Mode bits only change while the channel is off
  task automatic setup(input int ch, input logic r, sd, dd, sz,
                       input logic [15:0] c, sa, da);
    @(negedge mclk);
    ring_mode[ch] = r;
    source_direction_select[ch] = sd;
    destination_direction_select[ch] = dd;
    unit_size_select[ch] = sz;
    write_reg(K_CNT, NCH'(1) << ch, c);
    write_reg(K_SRC, NCH'(1) << ch, sa);
    write_reg(K_DST, NCH'(1) << ch, da);
  endtask : setup

  // Bounded wait for the enables in m to drop
  task automatic wait_off(input logic [NCH-1:0] m);
    n = 0;
    while ((channel_transfer_enable & m) != '0 && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    check(16'(n < 4000), 16'h0001, "run end");
  endtask : wait_off

  function automatic logic [7:0] rb(input logic [15:0] a);
    logic [15:0] w;
    w = i_dma_bus_partner.mem[a[15:1]];
    return a[0] ? w[7:0] : w[15:8];
  endfunction : rb

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    {enable_set, enable_clr, ring_mode, req_flag_clr} = '0;
    {source_direction_select, destination_direction_select} = '0;
    {unit_size_select, cnt_wr, src_wr, dst_wr, status_wdata} = '0;
    {irq_mask, request_source_select, request_in, sw_wdata} = '0;
    {status_wr, slow, hold} = '0;
    repeat (5) @(negedge mclk);
    resetn = 1'b1;
    check(16'(active_chan), 16'(CH_NONE), "idle chan");
    // Byte run from an odd source; count write while on is dropped
    setup(2, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0002, 16'h0101, 16'h0200);
    write_reg(K_EN, 10'h004, '0);
    w0 = wr_count;
    b0 = busy_cycles;
    write_reg(K_CNT, 10'h004, 16'h0050);
    check(16'(xfer_count[2]), 16'h0002, "locked count");
    request_in[2][0] = 1'b1;
    wait_off(10'h004);
    request_in[2][0] = 1'b0;
    check(16'(wr_count - w0), 16'h0003, "units");
    check(16'(busy_cycles - b0), 16'h0009, "bus cycles");
    check(16'(xfer_count[2]), 16'h00FF, "end count");
    check(src_addr[2], 16'h0104, "src end");
    check(dst_addr[2], 16'h0203, "dst end");
    for (int i = 0; i < 3; i++) begin
      check(16'(rb(16'(16'h0200 + i))), 16'(rb(16'(16'h0101 + i))),
            "byte");
    end
    check(16'(irq_status[2]), 16'h0001, "status");
    check(16'(dma_irq), 16'h0001, "irq");
    irq_mask[2] = 1'b1;
    repeat (2) @(negedge mclk);
    check(16'(dma_irq), 16'h0000, "masked");
    irq_mask[2] = 1'b0;
    write_reg(K_STAT, '1, '0);
    check(16'(irq_status[2]), 16'h0001, "ones keep");
    write_reg(K_STAT, 10'h3FB, '0);
    @(negedge mclk);
    check(16'(irq_status[2]), 16'h0000, "zero clears");
    check(16'(dma_irq), 16'h0000, "irq off");
    $display("Byte run test done");
    // Halfword, fixed odd source, slow bus, then rerun without reload
    setup(5, 1'b0, 1'b0, 1'b1, 1'b1, 16'h0001, 16'h0301, 16'h0400);
    slow = 1'b1;
    request_source_select[5] = 2'h1;
    write_reg(K_EN, 10'h020, '0);
    w0 = wr_count;
    request_in[5][1] = 1'b1;
    wait_off(10'h020);
    check(16'(wr_count - w0), 16'h0002, "units");
    check(src_addr[5], 16'h0301, "fixed src");
    check(dst_addr[5], 16'h0404, "dst end");
    check({rb(16'h0402), rb(16'h0403)}, {rb(16'h0300), rb(16'h0301)},
          "half");
    w0 = wr_count;
    write_reg(K_EN, 10'h020, '0);
    wait_off(10'h020);
    request_in[5][1] = 1'b0;
    slow = 1'b0;
    check(16'(wr_count - w0), 16'h0100, "rerun units");
    check(dst_addr[5], 16'h0604, "rerun dst");
    $display("Halfword test done");
    // Ring: bytes wrap the source only, halfwords wrap both ends
    for (int i = 0; i < 2; i++) begin
      setup(7 + i, 1'b1, 1'b1, 1'(i), 1'(i), 16'h0000, 16'h0500,
            16'h0700);
      write_reg(K_EN, NCH'(1) << (7 + i), '0);
      w0 = wr_count;
      request_in[7 + i][0] = 1'b1;
      n = 0;
      while (wr_count - w0 < 40 && n < 400) begin
        @(negedge mclk);
        n++;
      end
      check(16'(channel_transfer_enable[7 + i]), 16'h0001, "free");
      write_reg(K_OFF, NCH'(1) << (7 + i), '0);
      request_in[7 + i][0] = 1'b0;
      wait_off(NCH'(1) << (7 + i));
      repeat (6) @(negedge mclk);
      n = wr_count - w0;
      check(src_addr[7 + i], i ? 16'(16'h0500 + 2 * n % 64)
            : 16'(16'h0500 + n % 32), "ring src");
      check(dst_addr[7 + i], i ? 16'(16'h0700 + 2 * n % 64) : 16'h0700,
            "ring dst");
      check(16'(irq_status[7 + i]), 16'h0000, "no irq");
    end
    $display("Ring test done");
    // Priority, request before enable, flag clear while the bus is held
    setup(0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0801, 16'h0900);
    setup(3, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0802, 16'h0901);
    request_source_select[0] = 2'h2;
    hold = 1'b1;
    request_in[3][0] = 1'b1;
    repeat (3) @(negedge mclk);
    check(16'(bus_req), 16'h0000, "not enabled");
    request_in[3][0] = 1'b0;
    write_reg(K_EN, 10'h009, '0);
    request_in[0][2] = 1'b1;
    request_in[3][0] = 1'b1;
    repeat (3) @(negedge mclk);
    check(16'(active_chan), 16'h0000, "winner");
    check(16'(req_flag[3]), 16'h0001, "pending");
    request_in[3][0] = 1'b0;
    write_reg(K_FCLR, 10'h008, '0);
    check(16'(req_flag[3]), 16'h0000, "flag clr");
    hold = 1'b0;
    wait_off(10'h001);
    request_in[0][2] = 1'b0;
    repeat (6) @(negedge mclk);
    check(16'(channel_transfer_enable[3]), 16'h0001, "still on");
    check(16'(xfer_count[3]), 16'h0000, "no move");
    check(16'(rb(16'h0900)), 16'(rb(16'h0801)), "moved");
    write_reg(K_OFF, 10'h008, '0);
    $display("Priority test done");
    wrap_up();
  end

  // Watchdog well beyond the expected run of some 1400 cycles
  initial begin
    #(40 * 8000);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : dma_channel_transfer_engine_tb
